// *** hw/eeprom_pkg.sv ***
// constants and types shared by the two-wire eeprom target
package eeprom_pkg;
  // array and word geometry
  localparam int          DATA_W      = 8;
  localparam int          ADDR_W      = 8;
  localparam int          OFF_W       = 4;
  localparam int          PAGE_BYTES  = 16;
  localparam int          MEM_BYTES   = 256;
  localparam int          FIFO_DEPTH  = 16;
  localparam int          ENTRY_W     = OFF_W + DATA_W;
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;
  // bits in one serial word before the acknowledge clock
  localparam logic [3:0]  WORD_BITS   = 4'h8;
  // direction bit value that selects a read
  localparam logic        DIR_READ    = 1'h1;
  // programming time and clock rate
  localparam int unsigned TWC_US      = 5000;
  localparam int unsigned CLK_KHZ     = 40000;
  localparam int unsigned TWC_CYCLES  = (TWC_US * CLK_KHZ) / 1000;

  // transaction phase of the target
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_MEMADDR,
    ST_WRDATA,
    ST_RDDATA
  } state_e;
endpackage : eeprom_pkg

// *** hw/eeprom_ifs.sv ***
// interfaces carrying the sampled bus lines and the write data stream
`timescale 1ns/100ps
interface line_if;
  logic       scl;
  logic       sda;
  logic       wp;
  logic [2:0] sel;
  logic       scl_rise;
  logic       scl_fall;
  logic       start;
  logic       stop;
  modport sync (output scl, sda, wp, sel, scl_rise, scl_fall, start, stop);
  modport core (input  scl, sda, wp, sel, scl_rise, scl_fall, start, stop);
endinterface : line_if

interface stream_if #(parameter int W = 12);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport src  (output in_valid, in_data, input in_ready);
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport snk  (input out_valid, out_data, output out_ready);
endinterface : stream_if

// *** hw/pin_sync.sv ***
// synchroniser and edge, start and stop finder for the bus pins
`timescale 1ns/100ps
module pin_sync (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       wp_i,
  input  wire logic [2:0] sel_i,
  line_if.sync            ln
);
  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;

  // two flops per pin, then one more stage of clock and data for edges
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q     <= 6'h3F;
      sync_q     <= 6'h3F;
      scl_prev_q <= 1'h1;
      sda_prev_q <= 1'h1;
    end else begin
      meta_q     <= {sel_i, wp_i, sda_i, scl_i};
      sync_q     <= meta_q;
      scl_prev_q <= sync_q[0];
      sda_prev_q <= sync_q[1];
    end
  end

  // open pins are pulled low outside, so they simply read as low here
  assign ln.scl      = sync_q[0];
  assign ln.sda      = sync_q[1];
  assign ln.wp       = sync_q[2];
  assign ln.sel      = sync_q[5:3];
  assign ln.scl_rise = sync_q[0] & ~scl_prev_q;
  assign ln.scl_fall = ~sync_q[0] & scl_prev_q;
  // data edges while the clock stays high mark start and stop
  assign ln.start    = sync_q[0] & scl_prev_q & sda_prev_q & ~sync_q[1];
  assign ln.stop     = sync_q[0] & scl_prev_q & ~sda_prev_q & sync_q[1];
endmodule : pin_sync

// *** hw/byte_fifo.sv ***
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic clock_i,
  input  wire logic resetn_i,
  stream_if.fifo    s
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              full;
  wire              empty;
  wire              push;
  wire              pop;

  // pointer compare with one wrap bit gives honest full and empty
  assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty       = (wr_q == rd_q);
  assign push        = s.in_valid && !full;
  assign pop         = s.out_ready && !empty;
  assign s.in_ready  = !full;
  assign s.out_valid = !empty;
  assign s.out_data  = buf_q[rd_q[AW-1:0]];

  // pointers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  // storage
  always_ff @(posedge clock_i) begin
    if (push) buf_q[wr_q[AW-1:0]] <= s.in_data;
  end
endmodule : byte_fifo

// *** hw/eeprom_target.sv ***
// two-wire serial eeprom target: bus protocol, page write and array
// How it works
// RULE_01: take data bits on clock rise, change our data only after clock fall.
// RULE_02: data line changes only while clock low, except start and stop.
// RULE_03: data falling with clock high is start; it begins a new transaction.
// RULE_04: data rising with clock high is stop; after a read return to standby.
// RULE_05: stop after accepted write data starts timed programming; bus ignored meanwhile.
// RULE_06: every word is eight bits plus a ninth clock where receiver pulls low.
// RULE_07: on writes without protection, acknowledge every received word.
// RULE_08: after a read byte release data; a low acknowledge sends next address.
// RULE_09: high acknowledge then stop ends the read and returns to standby.
// RULE_10: no acknowledge and no stop: keep data released, send nothing more.
// RULE_11: first word after start is type code, select code, direction bit.
// RULE_12: answer only if type and select code match, else standby silently.
// RULE_13: direction bit zero means write, one means read.
// RULE_14: unconnected select pins read low, allowing eight devices per bus.
// RULE_15: byte write is address word, memory address, one data byte, then stop.
// RULE_16: more data bytes make a page write of up to sixteen bytes.
// RULE_17: page write steps only low four address bits, wrapping inside the page.
// RULE_18: with protection, acknowledge both addresses but refuse data and skip programming.
// RULE_19: protected page write refuses from first data byte, writing nothing.
// RULE_20: protection guards whole array; reads work regardless of protection.
// RULE_21: unconnected protect input reads low, array stays writable.
// RULE_22: while programming, leave write address word unacknowledged for polling.
// RULE_23: programming ends within five milliseconds of the stop.
// RULE_24: array of 256 bytes, addressed directly, erased state all ones.
`timescale 1ns/100ps
module eeprom_target import eeprom_pkg::*; #(
  parameter logic [3:0]  TYPE_CODE    = 4'h5,        // arbitrary value
  parameter int unsigned WRITE_CYCLES = TWC_CYCLES
) (
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       write_protect_i,
  input  wire logic [2:0] hardwired_select_pins_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            busy_o
);
  line_if                     ln ();
  stream_if #(.W(ENTRY_W))    fq ();

  state_e                     state_q;
  state_e                     state_d;
  logic [3:0]                 cnt_q;
  logic [3:0]                 cnt_d;
  logic                       ack_q;
  logic                       ack_d;
  logic                       oe_q;
  logic                       oe_d;
  logic [DATA_W-1:0]          shift_q;
  logic [DATA_W-1:0]          tx_q;
  logic [ADDR_W-1:0]          addr_q;
  logic                       have_data_q;
  logic                       refused_q;
  logic                       busy_q;
  logic [31:0]                timer_q;
  logic [OFF_W-1:0]           page_q;
  logic [PAGE_BYTES-1:0]      mask_q;
  logic [DATA_W-1:0]          page_data [PAGE_BYTES];
  logic [DATA_W-1:0]          mem [MEM_BYTES];

  wire                        rx_state;
  wire                        rx_bit;
  wire                        tx_bit;
  wire                        word_end;
  wire                        ack_end;
  wire                        rd_sample;
  wire                        dev_match;
  wire                        is_read;
  wire                        ack_give;
  wire                        push;
  wire                        load_rd;
  wire                        commit;
  wire                        discard;
  wire                        drain;
  wire                        prog_done;
  wire [DATA_W-1:0]           rd_byte;
  wire [OFF_W-1:0]            drain_off;

  // pin sampling and start, stop and edge finding
  pin_sync u_sync (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .scl_i    (scl_i),
    .sda_i    (sda_i),
    .wp_i     (write_protect_i),                      // [RULE_21]
    .sel_i    (hardwired_select_pins_i),              // [RULE_14]
    .ln       (ln.sync)
  );

  // accepted write bytes queue here before landing in the page latch
  byte_fifo #(.WIDTH(ENTRY_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_i  (clock_i),
    .resetn_i (resetn_i),
    .s        (fq.fifo)
  );

  // bit timing decode on the sampled clock edges
  assign rx_state  = (state_q == ST_DEVADDR) || (state_q == ST_MEMADDR) ||
                     (state_q == ST_WRDATA);
  assign rx_bit    = ln.scl_rise && rx_state && !ack_q && (cnt_q != WORD_BITS); // [RULE_01]
  assign tx_bit    = ln.scl_fall && (state_q == ST_RDDATA) && !ack_q &&
                     (cnt_q != WORD_BITS);                                     // [RULE_01]
  assign word_end  = ln.scl_fall && !ack_q && (cnt_q == WORD_BITS);            // [RULE_06]
  assign ack_end   = ln.scl_fall && ack_q;
  assign rd_sample = ln.scl_rise && ack_q && (state_q == ST_RDDATA);

  // address word decode: type code, select code, direction last
  assign dev_match = (shift_q[7:4] == TYPE_CODE) && (shift_q[3:1] == ln.sel); // [RULE_11]
  assign is_read   = (shift_q[0] == DIR_READ);                                 // [RULE_13]

  // acknowledge decision per word type
  assign ack_give  = (state_q == ST_DEVADDR) ? (dev_match && !busy_q) :       // [RULE_12] [RULE_22]
                     (state_q == ST_MEMADDR) ? 1'b1 :                          // [RULE_07]
                     (state_q == ST_WRDATA)  ? (!ln.wp && !refused_q &&
                                                fq.in_ready) :                 // [RULE_18] [RULE_19]
                     1'b0;

  // data byte acceptance and read loading
  assign push      = word_end && (state_q == ST_WRDATA) && ack_give;          // [RULE_16]
  assign load_rd   = ack_end && ((state_q == ST_RDDATA) ||
                     ((state_q == ST_DEVADDR) && is_read));                    // [RULE_08] [RULE_20]
  assign rd_byte   = mem[addr_q];

  // stop with clean pending data programs; any other end drops the page, except one while programming is under way
  assign commit    = ln.stop && have_data_q && !refused_q && !busy_q;         // [RULE_05]
  assign discard   = (ln.start || ln.stop) && !commit;                         // [RULE_19]
  assign prog_done = busy_q && (timer_q == WRITE_CYCLES - 1);                  // [RULE_23]

  // the page latch drains the queue except while it is being programmed
  assign fq.in_valid  = push;
  assign fq.in_data   = {addr_q[OFF_W-1:0], shift_q};
  assign fq.out_ready = !busy_q;
  assign drain        = fq.out_valid && fq.out_ready;
  assign drain_off    = fq.out_data[ENTRY_W-1:DATA_W];

  // open-drain data pin: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_o = oe_q;
  assign busy_o   = busy_q;

  // transaction phase
  always_comb begin
    state_d = state_q;
    if (ln.start) begin
      state_d = ST_DEVADDR;                                                    // [RULE_03]
    end else if (ln.stop) begin
      state_d = ST_IDLE;                                                       // [RULE_04] [RULE_09]
    end else begin
      case (state_q)
        ST_DEVADDR: begin
          if (word_end && !ack_give) state_d = ST_IDLE;                        // [RULE_12]
          else if (ack_end) state_d = is_read ? ST_RDDATA : ST_MEMADDR;        // [RULE_15]
        end
        ST_MEMADDR: begin
          if (ack_end) state_d = ST_WRDATA;
        end
        ST_WRDATA: begin
          if (word_end && !ack_give) state_d = ST_IDLE;                        // [RULE_18]
        end
        ST_RDDATA: begin
          if (rd_sample && ln.sda) state_d = ST_IDLE;                          // [RULE_10]
        end
        default: state_d = state_q;
      endcase
    end
  end

  // bit counter and acknowledge phase
  always_comb begin
    cnt_d = cnt_q;
    ack_d = ack_q;
    if (ln.start || ln.stop || (state_d == ST_IDLE)) begin
      cnt_d = 4'h0;
      ack_d = 1'b0;
    end else if (rx_bit || tx_bit) begin
      cnt_d = cnt_q + 4'h1;
    end else if (word_end) begin
      ack_d = 1'b1;                                                            // [RULE_06]
    end else if (ack_end) begin
      cnt_d = load_rd ? 4'h1 : 4'h0;
      ack_d = 1'b0;
    end
  end

  // data pin drive, moved on a clock fall, or released at once on a start or stop
  always_comb begin
    oe_d = oe_q;
    if (ln.start || ln.stop || (state_d == ST_IDLE)) begin
      oe_d = 1'b0;
    end else if (word_end) begin
      oe_d = (state_q != ST_RDDATA) && ack_give;                               // [RULE_07] [RULE_08]
    end else if (ack_end) begin
      oe_d = load_rd ? ~rd_byte[DATA_W-1] : 1'b0;                              // [RULE_02]
    end else if (tx_bit) begin
      oe_d = ~tx_q[DATA_W-1];                                                  // [RULE_01]
    end
  end

  // control registers
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      ack_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      ack_q   <= ack_d;
      oe_q    <= oe_d;
    end
  end

  // receive and transmit shifters
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_q <= 8'h00;
      tx_q    <= 8'h00;
    end else begin
      if (rx_bit)  shift_q <= {shift_q[DATA_W-2:0], ln.sda};
      if (load_rd) tx_q    <= {rd_byte[DATA_W-2:0], 1'b0};
      else if (tx_bit) tx_q <= {tx_q[DATA_W-2:0], 1'b0};
    end
  end

  // address counter: full step on reads, in-page step on writes
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      addr_q <= 8'h00;
    end else if (word_end && (state_q == ST_MEMADDR)) begin
      addr_q <= shift_q;
    end else if (push) begin
      addr_q <= {addr_q[ADDR_W-1:OFF_W], addr_q[OFF_W-1:0] + 4'h1};            // [RULE_17]
    end else if (load_rd) begin
      addr_q <= addr_q + 8'h01;
    end
  end

  // write transaction bookkeeping; a refusal sticks until the next start or stop
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      have_data_q <= 1'b0;
      refused_q   <= 1'b0;
    end else begin
      if (push) have_data_q <= 1'b1;
      else if (ln.start || ln.stop) have_data_q <= 1'b0;
      if (word_end && (state_q == ST_WRDATA) && !ack_give) refused_q <= 1'b1;  // [RULE_19]
      else if (ln.start || ln.stop) refused_q <= 1'b0;
    end
  end

  // programming timer; bus words meanwhile go unanswered
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busy_q  <= 1'b0;
      timer_q <= 32'h0;
      page_q  <= 4'h0;
    end else if (commit) begin
      busy_q  <= 1'b1;                                                         // [RULE_05]
      timer_q <= 32'h0;
      page_q  <= addr_q[ADDR_W-1:OFF_W];
    end else if (prog_done) begin
      busy_q  <= 1'b0;                                                         // [RULE_23]
    end else if (busy_q) begin
      timer_q <= timer_q + 32'h1;
    end
  end

  // page latch: which offsets hold new data
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_q <= '0;
    end else if (prog_done || (discard && !busy_q)) begin
      mask_q <= '0;                                                            // [RULE_18]
    end else if (drain) begin
      mask_q[drain_off] <= 1'b1;
    end
  end

  // page latch data; a later byte at the same offset overwrites
  always_ff @(posedge clock_i) begin
    if (drain) page_data[drain_off] <= fq.out_data[DATA_W-1:0];                // [RULE_17]
  end

  // array: erased after reset, page written at the end of programming
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < MEM_BYTES; i++) mem[i] <= ERASED_BYTE;               // [RULE_24]
    end else if (prog_done) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (mask_q[i]) mem[{page_q, 4'(i)}] <= page_data[i];                   // [RULE_20]
      end
    end
  end

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  pin_on_fall_a: assert property ($changed(oe_q) && !$past(ln.start) && !$past(ln.stop)
      && !$past(rd_sample) && $past(state_d) != ST_IDLE |-> $past(ln.scl_fall)) // [RULE_01]
    else $error("data drive moved away from a clock fall");
  start_begins_a: assert property (ln.start |=> state_q == ST_DEVADDR && !oe_q
      && cnt_q == 4'h0) // [RULE_03]
    else $error("start did not open an address word");
  stop_standby_a: assert property (ln.stop |=> state_q == ST_IDLE && !oe_q) // [RULE_04]
    else $error("stop did not return to standby");
  prog_launch_a: assert property (commit |=> busy_q ##1 busy_q) // [RULE_05]
    else $error("stop after write data did not start programming");
  addr_mismatch_a: assert property (word_end && state_q == ST_DEVADDR && !dev_match
      |=> !oe_q && state_q == ST_IDLE) // [RULE_12]
    else $error("foreign address word was acknowledged");
  write_ack_a: assert property (word_end && state_q == ST_MEMADDR
      |=> oe_q && ack_q) // [RULE_07]
    else $error("memory address not acknowledged");
  protect_nack_a: assert property (word_end && state_q == ST_WRDATA && ln.wp
      |=> !oe_q && state_q == ST_IDLE) // [RULE_18]
    else $error("protected data byte was acknowledged");
  protect_push_a: assert property (push |-> !ln.wp && !refused_q) // [RULE_19]
    else $error("protected byte entered the page");
  poll_nack_a: assert property (word_end && state_q == ST_DEVADDR && busy_q
      |=> !oe_q) // [RULE_22]
    else $error("address word acknowledged during programming");
  page_wrap_a: assert property (push |=> addr_q[7:4] == $past(addr_q[7:4])
      && addr_q[3:0] == $past(addr_q[3:0]) + 4'h1) // [RULE_17]
    else $error("page write stepped outside the page");
  prog_bound_a: assert property (busy_q |-> timer_q < WRITE_CYCLES) // [RULE_23]
    else $error("programming ran past its time");
  read_release_a: assert property (word_end && state_q == ST_RDDATA
      |=> !oe_q [*2]) // [RULE_08]
    else $error("data not released for the read acknowledge");
  read_nack_a: assert property (rd_sample && ln.sda && !ln.stop && !ln.start
      |=> state_q == ST_IDLE && !oe_q) // [RULE_10]
    else $error("read went on without an acknowledge");

  byte_commit_c:  cover property (commit);
  seq_read_c:     cover property (load_rd && state_q == ST_RDDATA);
  protect_c:      cover property (word_end && state_q == ST_WRDATA && !ack_give);
  poll_busy_c:    cover property (word_end && state_q == ST_DEVADDR && busy_q);
endmodule : eeprom_target

// *** sim/bus_ctrl.sv ***
// behavioural two-wire bus controller that drives the clock and pulls data
`timescale 1ns/100ps
module bus_ctrl (
  input  wire logic clock_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      pull_o
);
  // bus idles with the clock high and data released
  initial begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end

  // one 200 ns bit: data set mid-low, sampled at the end of the high phase
  task automatic bit_c(input logic b, output logic r);
    repeat (2) @(posedge clock_i);
    pull_o <= ~b;                          // data moves only with the clock low
    repeat (2) @(posedge clock_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    r = sda_i;
    scl_o <= 1'b0;
  endtask : bit_c

  // start, also serves as a repeated start
  task automatic start_c();
    repeat (2) @(posedge clock_i);
    pull_o <= 1'b0;
    repeat (2) @(posedge clock_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    pull_o <= 1'b1;                        // data falls with the clock high
    repeat (4) @(posedge clock_i);
    scl_o <= 1'b0;
  endtask : start_c

  // stop leaves the bus idle
  task automatic stop_c();
    repeat (2) @(posedge clock_i);
    pull_o <= 1'b1;
    repeat (2) @(posedge clock_i);
    scl_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    pull_o <= 1'b0;                        // data rises with the clock high
    repeat (4) @(posedge clock_i);
  endtask : stop_c

  // send a word msb first, then release for the ninth clock
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_c(d[i], r);  // eight bits msb first
    bit_c(1'b1, r);                        // released ninth clock
    ack = ~r;
  endtask : wr_byte

  // take a word, then answer low to continue or high to end
  task automatic rd_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_c(1'b1, r);
      d[i] = r;
    end
    bit_c(~more, r);                       // acknowledge or end
  endtask : rd_byte
endmodule : bus_ctrl

// *** sim/testbench.sv ***
// self-checking bench for the two-wire eeprom target against a byte model
`timescale 1ns/100ps
module testbench;
  import eeprom_pkg::*;
  localparam logic [3:0] TYPE = 4'h5;      // arbitrary value
  logic       clock_i, resetn_i, wp_q, busy_o, sda_o, sda_oe_o, scl, pull;
  logic [2:0] sel_q;
  wire        sda = ~(pull | (sda_oe_o & ~sda_o)); // pull-up resolves the open-drain line
  int         failures, total_checks, seed;
  logic [7:0] mem [MEM_BYTES];

  eeprom_target #(.TYPE_CODE(TYPE), .WRITE_CYCLES(200)) uut (
    .clock_i(clock_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
    .write_protect_i(wp_q), .hardwired_select_pins_i(sel_q),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o));
  bus_ctrl ctrl (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));

  // 40 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  function automatic logic [7:0] dw(input logic rd);
    return {TYPE, sel_q, rd};
  endfunction : dw

  // write n random bytes from address a; the model commits after programming
  task automatic write_txn(input logic [7:0] a, input int n, input logic prot);
    logic ack;
    logic [7:0] d;
    logic [7:0] pa [$];
    logic [7:0] pd [$];
    int k;
    wp_q <= prot;
    ctrl.start_c();
    ctrl.wr_byte(dw(1'b0), ack);
    check(ack, 1'b1);
    ctrl.wr_byte(a, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      ctrl.wr_byte(d, ack);
      check(ack, !prot);
      pa.push_back({a[7:4], a[3:0] + 4'(i)});
      pd.push_back(d);
    end
    ctrl.stop_c();
    check(busy_o, !prot);
    if (!prot) begin
      ctrl.start_c();
      ctrl.wr_byte(dw(1'b0), ack);
      check(ack, 1'b0);
      ctrl.stop_c();
      k = 0;
      while (busy_o === 1'b1 && k < 400) begin
        @(posedge clock_i);
        k++;
      end
      check(busy_o, 1'b0);
      foreach (pa[j]) mem[pa[j]] = pd[j];  // later bytes overwrite
    end
  endtask : write_txn

  // random read of n bytes; optionally one more byte after the ending no-ack
  task automatic read_txn(input logic [7:0] a, input int n, input logic extra);
    logic ack;
    logic [7:0] d;
    wp_q <= 1'($urandom);                  // reads ignore protection
    ctrl.start_c();
    ctrl.wr_byte(dw(1'b0), ack);
    check(ack, 1'b1);
    ctrl.wr_byte(a, ack);
    check(ack, 1'b1);
    ctrl.start_c();
    ctrl.wr_byte(dw(1'b1), ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      ctrl.rd_byte(i < n - 1, d);
      check(d, mem[8'(a + i)]);
    end
    if (extra) begin
      ctrl.rd_byte(1'b0, d);
      check(d, 8'hFF);
    end
    ctrl.stop_c();
  endtask : read_txn

  // address word that must be ignored
  task automatic reject(input logic [7:0] w);
    logic ack;
    ctrl.start_c();
    ctrl.wr_byte(w, ack);
    check(ack, 1'b0);
    ctrl.stop_c();
  endtask : reject

  // read without a dummy write, from where the last access left the address
  task automatic cur_read(input logic [7:0] a);
    logic ack;
    logic [7:0] d;
    ctrl.start_c();
    ctrl.wr_byte(dw(1'b1), ack);
    check(ack, 1'b1);
    ctrl.rd_byte(1'b0, d);
    check(d, mem[a]);
    ctrl.stop_c();
  endtask : cur_read

  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    seed = $urandom(55);
    failures = 0;
    total_checks = 0;
    resetn_i <= 1'b0;
    wp_q <= 1'b0;
    sel_q <= 3'($urandom);
    for (int i = 0; i < MEM_BYTES; i++) mem[i] = ERASED_BYTE;
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    read_txn(8'($urandom), 2, 1'b0);
    write_txn(8'h3A, 1, 1'b0);
    write_txn(8'h5E, 18, 1'b0);
    cur_read(8'h50);
    read_txn(8'h50, 16, 1'b1);
    write_txn(8'h3A, 2, 1'b1);
    read_txn(8'h3A, 1, 1'b0);
    reject({TYPE, ~sel_q, 1'b0});
    reject({~TYPE, sel_q, 1'b1});
    report_and_stop();
  end

  // watchdog against a hung bus
  initial begin
    #(25 * 40000);
    failures++;
    report_and_stop();
  end
endmodule : testbench
